// [usb_irq_enable_and_address.sv]
// USB interrupt enable gating, event status and device address registers on Wishbone
//
// The Wishbone register port and the register offsets were decided locally.
`include "usb_irq_consts.svh"

module usb_irq_enable_and_address #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [`DATA_W-1:0] wb_dat_in,
	output logic [`DATA_W-1:0] wb_dat_out,
	output logic wb_ack_out,
	// Event pulses from the USB core
	input wire logic stall_event_in,
	input wire logic attach_event_in,
	input wire logic resume_event_in,
	input wire logic idle_event_in,
	input wire logic token_done_event_in,
	input wire logic frame_start_event_in,
	input wire logic error_event_in,
	input wire logic bus_reset_event_in,
	input wire logic detach_event_in,
	// Interrupt and configuration outputs
	output logic usb_irq_out,
	output logic low_speed_select_out,
	output usb_irq_pkg::dev_addr_t device_address_out,
	output logic host_mode_out
);
	import usb_irq_pkg::*;

	if (ADDR_W < `OFS_W)
	begin : addr_check
		$error("address bus too narrow for the register map");
	end

	bus_state_t bus_state;
	event_vec_t usb_irq_enable;
	event_vec_t event_raw;
	event_vec_t clear_vec;
	event_vec_t status_flags;
	logic bus_take;
	logic wr_take;

	// Full address compare so that aliases above the map stay unmapped
	function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [`OFS_W-1:0] ofs);
		return adr == ADDR_W'(ofs);
	endfunction : reg_hit

	assign bus_take = wb_cyc_in && wb_stb_in && (bus_state == BUS_IDLE);
	// All registers live in byte lane 0; other lanes carry nothing
	assign wr_take = bus_take && wb_we_in && wb_sel_in[0];

	// Bus handshake: one wait state, ack for one cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bus_state <= BUS_IDLE;
			wb_ack_out <= 1'b0;
		end
		else
		begin
			case (bus_state)
				BUS_IDLE:
				begin
					if (wb_cyc_in && wb_stb_in)
					begin
						bus_state <= BUS_ACK;
						wb_ack_out <= 1'b1;
					end
				end
				BUS_ACK:
				begin
					bus_state <= BUS_IDLE;
					wb_ack_out <= 1'b0;
				end
				default:
				begin
					bus_state <= BUS_IDLE;
					wb_ack_out <= 1'b0;
				end
			endcase
		end
	end

	// Read data captured with the request; unmapped offsets read zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			wb_dat_out <= `RESET_WORD;
		else if (bus_take && !wb_we_in)
		begin
			if (reg_hit(wb_adr_in, `OFS_IRQ_ENABLE))
				wb_dat_out <= {`UPPER_ZERO, usb_irq_enable};
			else if (reg_hit(wb_adr_in, `OFS_DEV_ADDR))
				wb_dat_out <= {`UPPER_ZERO, low_speed_select_out, device_address_out};
			else if (reg_hit(wb_adr_in, `OFS_IRQ_STATUS))
				wb_dat_out <= {`UPPER_ZERO, status_flags};
			else if (reg_hit(wb_adr_in, `OFS_MODE))
				wb_dat_out <= {`UPPER_ZERO, 7'h00, host_mode_out};
			else
				wb_dat_out <= `RESET_WORD;
		end
	end

	// Interrupt enable register, low byte only
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			usb_irq_enable <= `RESET_BYTE;
		else if (wr_take && reg_hit(wb_adr_in, `OFS_IRQ_ENABLE))
			usb_irq_enable <= wb_dat_in[`EVENT_W-1:0];
	end

	// Device address and speed select
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			low_speed_select_out <= 1'b0;
			device_address_out <= '0;
		end
		else if (wr_take && reg_hit(wb_adr_in, `OFS_DEV_ADDR))
		begin
			low_speed_select_out <= wb_dat_in[`BIT_LOW_SPEED];
			device_address_out <= wb_dat_in[`DEV_ADDR_W-1:0];
		end
	end

	// Host or device role of the shared bit 0 source
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			host_mode_out <= 1'b0;
		else if (wr_take && reg_hit(wb_adr_in, `OFS_MODE))
			host_mode_out <= wb_dat_in[`BIT_HOST_MODE];
	end

	// Event sources mapped onto the enable layout
	always_comb
	begin
		event_raw = '0;
		event_raw[`BIT_STALL] = stall_event_in;
		event_raw[`BIT_ATTACH] = attach_event_in;
		event_raw[`BIT_RESUME] = resume_event_in;
		event_raw[`BIT_IDLE] = idle_event_in;
		event_raw[`BIT_TOKEN_DONE] = token_done_event_in;
		event_raw[`BIT_FRAME_START] = frame_start_event_in;
		event_raw[`BIT_ERROR] = error_event_in;
		// Bus reset means nothing to a host, detach nothing to a device
		event_raw[`BIT_RESET_DETACH] = host_mode_out ? detach_event_in : bus_reset_event_in;
	end

	// Clear register is write-only: a one clears, a zero leaves alone
	always_comb
	begin
		clear_vec = '0;
		if (wr_take && reg_hit(wb_adr_in, `OFS_IRQ_CLEAR))
			clear_vec = wb_dat_in[`EVENT_W-1:0];
	end

	event_flags #(
		.WIDTH(`EVENT_W)
	) flags_bank (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.set_in(event_raw),
		.clear_in(clear_vec),
		.flags_out(status_flags)
	);

	// Flags always record; only the enable decides what reaches the pin
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			usb_irq_out <= 1'b0;
		else
			usb_irq_out <= |(status_flags & usb_irq_enable);
	end

	stall_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_STALL] && usb_irq_enable[`BIT_STALL]) |=> usb_irq_out)
		else $error("enabled stall flag gave no interrupt");

	attach_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_ATTACH] && usb_irq_enable[`BIT_ATTACH]) |=> usb_irq_out)
		else $error("enabled attach flag gave no interrupt");

	resume_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_RESUME] && usb_irq_enable[`BIT_RESUME]) |=> usb_irq_out)
		else $error("enabled resume flag gave no interrupt");

	idle_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_IDLE] && usb_irq_enable[`BIT_IDLE]) |=> usb_irq_out)
		else $error("enabled idle flag gave no interrupt");

	token_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(status_flags[`BIT_TOKEN_DONE]) && usb_irq_enable[`BIT_TOKEN_DONE] |=> usb_irq_out)
		else $error("token completion gave no interrupt");

	frame_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_FRAME_START] && usb_irq_enable[`BIT_FRAME_START]) |=> usb_irq_out)
		else $error("enabled frame start flag gave no interrupt");

	error_gate_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(status_flags[`BIT_ERROR] && usb_irq_enable[`BIT_ERROR]) |=> usb_irq_out)
		else $error("enabled error flag gave no interrupt");

	error_masked_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!usb_irq_enable[`BIT_ERROR] && (status_flags & usb_irq_enable) == '0) |=> !usb_irq_out)
		else $error("masked event raised the interrupt");

	reset_source_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_reset_event_in && !host_mode_out) |=> status_flags[`BIT_RESET_DETACH])
		else $error("bus reset not recorded in device mode");

	detach_source_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(host_mode_out && bus_reset_event_in && !detach_event_in && !status_flags[`BIT_RESET_DETACH])
		|=> !status_flags[`BIT_RESET_DETACH])
		else $error("bus reset recorded in host mode");

	upper_zero_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wb_ack_out |-> (wb_dat_out[`DATA_W-1:`EVENT_W] == `UPPER_ZERO))
		else $error("upper read bits not zero");

	addr_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_take && reg_hit(wb_adr_in, `OFS_DEV_ADDR))
		|=> (device_address_out == $past(wb_dat_in[`DEV_ADDR_W-1:0]))
		&& (low_speed_select_out == $past(wb_dat_in[`BIT_LOW_SPEED])))
		else $error("address register write lost");

	ack_pulse_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not a single pulse after request");

	// Register contents follow only their own writes
	enable_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_take && reg_hit(wb_adr_in, `OFS_IRQ_ENABLE))
		|=> (usb_irq_enable == $past(wb_dat_in[`EVENT_W-1:0])))
		else $error("enable register write lost");

	enable_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(wr_take && reg_hit(wb_adr_in, `OFS_IRQ_ENABLE)) |=> $stable(usb_irq_enable))
		else $error("enable register changed without a write");

	addr_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(wr_take && reg_hit(wb_adr_in, `OFS_DEV_ADDR))
		|=> ($stable(device_address_out) && $stable(low_speed_select_out)))
		else $error("address register changed without a write");

	mode_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_take && reg_hit(wb_adr_in, `OFS_MODE)) |=> (host_mode_out == $past(wb_dat_in[`BIT_HOST_MODE])))
		else $error("mode register write lost");

	mode_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(wr_take && reg_hit(wb_adr_in, `OFS_MODE)) |=> $stable(host_mode_out))
		else $error("mode register changed without a write");

	// A write that leaves lane zero off must not touch any register
	lane_guard_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_take && wb_we_in && !wb_sel_in[0])
		|=> ($stable(usb_irq_enable) && $stable(device_address_out) && $stable(host_mode_out)))
		else $error("write without lane zero changed a register");

	read_keeps_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_take && !wb_we_in)
		|=> ($stable(usb_irq_enable) && $stable(device_address_out) && $stable(host_mode_out)))
		else $error("read changed a register");

	// Read path and handshake
	enable_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_take && !wb_we_in && reg_hit(wb_adr_in, `OFS_IRQ_ENABLE))
		|=> (wb_dat_out == {`UPPER_ZERO, $past(usb_irq_enable)}))
		else $error("enable register read wrong");

	addr_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_take && !wb_we_in && reg_hit(wb_adr_in, `OFS_DEV_ADDR))
		|=> (wb_dat_out == {`UPPER_ZERO, $past(low_speed_select_out), $past(device_address_out)}))
		else $error("address register read wrong");

	status_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bus_take && !wb_we_in && reg_hit(wb_adr_in, `OFS_IRQ_STATUS))
		|=> (wb_dat_out == {`UPPER_ZERO, $past(status_flags)}))
		else $error("status register read wrong");

	data_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(bus_take && !wb_we_in) |=> $stable(wb_dat_out))
		else $error("read data changed without a read");

	ack_idle_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!(wb_cyc_in && wb_stb_in) && !wb_ack_out) |=> !wb_ack_out)
		else $error("ack without a request");

	ack_drop_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");

	state_onehot_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$onehot(bus_state))
		else $error("bus state not one-hot");

	// Whole-word view of the gating, so a per-bit slip cannot hide behind the per-source checks
	irq_match_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		usb_irq_out == $past(|(status_flags & usb_irq_enable)))
		else $error("interrupt not the gated OR of the flags");

	clear_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_take && reg_hit(wb_adr_in, `OFS_IRQ_CLEAR) && (event_raw == '0))
		|=> ((status_flags & $past(wb_dat_in[`EVENT_W-1:0])) == '0))
		else $error("clear write left a flag set");

	flags_quiet_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		((event_raw == '0) && (clear_vec == '0)) |=> $stable(status_flags))
		else $error("status changed with no event and no clear");

	// Status bit 0 source follows the mode
	device_detach_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!host_mode_out && detach_event_in && !bus_reset_event_in && !status_flags[`BIT_RESET_DETACH])
		|=> !status_flags[`BIT_RESET_DETACH])
		else $error("detach recorded in device mode");

	host_detach_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(detach_event_in && host_mode_out) |=> status_flags[`BIT_RESET_DETACH])
		else $error("detach not recorded in host mode");

endmodule : usb_irq_enable_and_address

// [usb_irq_consts.svh]
// Offsets, bit positions and reset values of the USB interrupt enable and address block
`ifndef USB_IRQ_CONSTS_SVH
`define USB_IRQ_CONSTS_SVH

`define DATA_W 32
`define OFS_W 8
`define EVENT_W 8
`define DEV_ADDR_W 7

`define OFS_IRQ_ENABLE 8'h00
`define OFS_DEV_ADDR 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_CLEAR 8'h0C
`define OFS_MODE 8'h10

`define BIT_STALL 7
`define BIT_ATTACH 6
`define BIT_RESUME 5
`define BIT_IDLE 4
`define BIT_TOKEN_DONE 3
`define BIT_FRAME_START 2
`define BIT_ERROR 1
`define BIT_RESET_DETACH 0

`define BIT_LOW_SPEED 7
`define BIT_HOST_MODE 0

`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000
`define UPPER_ZERO 24'h00_0000

`endif

// [usb_irq_pkg.sv]
// Types shared by the USB interrupt enable and address block
package usb_irq_pkg;

	typedef logic [7:0] event_vec_t;
	typedef logic [6:0] dev_addr_t;

	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} bus_state_t;

endpackage : usb_irq_pkg

// [event_flags.sv]
// Sticky event flag bank with set-over-clear priority
module event_flags #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Set pulses and clear mask
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clear_in,
	// Flags
	output logic [WIDTH-1:0] flags_out
);

	if (WIDTH < 1)
	begin : width_check
		$error("event_flags needs at least one flag");
	end

	// An event landing on the clear cycle survives
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flags_out <= '0;
		else
			flags_out <= (flags_out & ~clear_in) | set_in;
	end

	set_wins_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(set_in != '0) |=> ((flags_out & $past(set_in)) == $past(set_in)))
		else $error("set pulse lost to clear");

	clear_acts_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
		((clear_in & ~set_in) != '0) |=> ((flags_out & $past(clear_in & ~set_in)) == '0))
		else $error("cleared flag still set");

endmodule : event_flags

// [tb_usb_irq_enable_and_address.sv]
// Self-checking bench for the USB interrupt enable and address block
`include "usb_irq_consts.svh"

module tb_usb_irq_enable_and_address;
	timeunit 1ns;
	timeprecision 1ps;
	import usb_irq_pkg::*;

	logic clk_in;
	logic rst_n_in;
	logic cyc, stb, we;
	logic [3:0] sel, lanes;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q, r;
	logic ack, irq, lspd, host;
	logic [8:0] ev;
	dev_addr_t dev_addr;
	int seed, fail_count, samples_checked, b;

	usb_irq_enable_and_address #(.ADDR_W(8)) u_usb_irq_enable_and_address (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.stall_event_in(ev[7]), .attach_event_in(ev[6]), .resume_event_in(ev[5]),
		.idle_event_in(ev[4]), .token_done_event_in(ev[3]), .frame_start_event_in(ev[2]),
		.error_event_in(ev[1]), .bus_reset_event_in(ev[0]), .detach_event_in(ev[8]),
		.usb_irq_out(irq), .low_speed_select_out(lspd), .device_address_out(dev_addr),
		.host_mode_out(host)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	// One classic cycle; the request stands until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= lanes;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			fail_count++;
			conclude();
		end
	endtask : bus

	task automatic pulse(input int k);
		@(posedge clk_in);
		ev <= 9'h001 << k;
		@(posedge clk_in);
		ev <= 9'h000;
		repeat (3) @(posedge clk_in);
	endtask : pulse

	function automatic logic [31:0] bit_mask(input int k);
		return 32'h0000_0001 << ((k == 8) ? 0 : k);
	endfunction : bit_mask

	initial
	begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		conclude();
	end

	initial
	begin
		seed = 50;
		rst_n_in = 1'b0;
		{cyc, stb, we} = 3'h0;
		sel = 4'hF;
		lanes = 4'hF;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		ev = 9'h000;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		chk("irq after reset", 32'h0, {31'h0, irq});
		bus(1'b0, `OFS_IRQ_ENABLE, 32'h0, q);
		chk("enable reset", 32'h0, q);
		bus(1'b0, `OFS_DEV_ADDR, 32'h0, q);
		chk("address reset", 32'h0, q);
		for (int i = 0; i < 6; i++)
		begin
			r = $random(seed);
			if (i == 0)
				r = 32'hFFFF_FFFF;
			bus(1'b1, `OFS_IRQ_ENABLE, r, q);
			bus(1'b0, `OFS_IRQ_ENABLE, 32'h0, q);
			chk("enable readback", {24'h0, r[7:0]}, q);
			r = $random(seed);
			bus(1'b1, `OFS_DEV_ADDR, r, q);
			chk("address field", {25'h0, r[6:0]}, {25'h0, dev_addr});
			chk("low speed", {31'h0, r[7]}, {31'h0, lspd});
			bus(1'b0, `OFS_DEV_ADDR, 32'h0, q);
			chk("address readback", {24'h0, r[7:0]}, q);
		end
		// Lane zero off: the write is acked but must leave the register alone
		lanes = 4'hE;
		bus(1'b1, `OFS_DEV_ADDR, ~r, q);
		lanes = 4'hF;
		bus(1'b0, `OFS_DEV_ADDR, 32'h0, q);
		chk("lane zero off", {24'h0, r[7:0]}, q);
		bus(1'b0, `OFS_IRQ_CLEAR, 32'h0, q);
		chk("clear reads zero", 32'h0, q);
		bus(1'b0, 8'h20, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		// Eight sources in device mode, then the detach source in host mode
		for (int k = 0; k < 9; k++)
		begin
			bus(1'b1, `OFS_MODE, {31'h0, k == 8}, q);
			chk("host mode", {31'h0, k == 8}, {31'h0, host});
			bus(1'b1, `OFS_IRQ_CLEAR, 32'h0000_00FF, q);
			bus(1'b1, `OFS_IRQ_ENABLE, ~bit_mask(k) & 32'h0000_00FF, q);
			pulse(k);
			chk("masked irq", 32'h0, {31'h0, irq});
			bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
			chk("status flag", bit_mask(k), q);
			bus(1'b1, `OFS_IRQ_ENABLE, bit_mask(k), q);
			repeat (2) @(posedge clk_in);
			chk("enabled irq", 32'h1, {31'h0, irq});
			bus(1'b1, `OFS_IRQ_CLEAR, bit_mask(k), q);
			repeat (2) @(posedge clk_in);
			chk("cleared irq", 32'h0, {31'h0, irq});
			b = (k == 8) ? 0 : 8;
			if (k == 0 || k == 8)
			begin
				pulse(b);
				bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
				chk("other mode source", 32'h0, q);
				chk("other mode irq", 32'h0, {31'h0, irq});
			end
		end
		// Reset in mid-run must bring every register and flag back to zero
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_00FF, q);
		bus(1'b1, `OFS_DEV_ADDR, 32'h0000_00FF, q);
		bus(1'b1, `OFS_MODE, 32'h0000_0001, q);
		pulse(7);
		chk("irq before reset", 32'h1, {31'h0, irq});
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		chk("irq in reset", 32'h0, {31'h0, irq});
		chk("mode after reset", 32'h0, {31'h0, host});
		chk("address after reset", 32'h0, {24'h0, lspd, dev_addr});
		bus(1'b0, `OFS_IRQ_ENABLE, 32'h0, q);
		chk("enable after reset", 32'h0, q);
		bus(1'b0, `OFS_IRQ_STATUS, 32'h0, q);
		chk("status after reset", 32'h0, q);
		conclude();
	end
endmodule : tb_usb_irq_enable_and_address
